// file: bcdadj_defs.svh
/*
 bcdadj_defs.svh: opcode fields, nibble limits and reset values for the bcd adjust / decrement unit.
 assumes it is included by bare name from the datapath module.
*/
`ifndef BCDADJ_DEFS_SVH
`define BCDADJ_DEFS_SVH

`define BCDADJ_OP_DECIMAL_ADJUST 16'h0007
`define BCDADJ_DEC_UPPER_MSB     15
`define BCDADJ_DEC_UPPER_LSB     10
`define BCDADJ_DEC_UPPER_VAL     6'h01
`define BCDADJ_DEST_BIT          9
`define BCDADJ_ADDR_MSB          7
`define BCDADJ_NIBBLE_MAX        4'h9
`define BCDADJ_NIBBLE_FIX        4'h6
`define BCDADJ_ONE               8'h01
`define BCDADJ_ZERO              8'h00
`define BCDADJ_W_RESET           8'h00
`define BCDADJ_OP_RESET          16'h0000
`define BCDADJ_NIB_ZERO          5'h00
`define BCDADJ_NIB_ONE           5'h01
`define BCDADJ_OV_OPERAND        8'h80

`endif

// file: bcdadj_pkg.sv
/*
 bcdadj_pkg: types for the bcd adjust / decrement unit.
 assumes bcdadj_defs.svh is on the include path.
*/
package bcdadj_pkg;
   typedef enum logic [1:0] {
      BCDADJ_DECODE,
      BCDADJ_READ,
      BCDADJ_PROCESS,
      BCDADJ_WRITE
   } bcdadj_phase_t;
endpackage : bcdadj_pkg

// file: bcdadj_unit.sv
/*
 bcdadj_unit: executes decimal adjust of the working register and decrement of a file register.
 assumes the core presents one opcode per instruction cycle with op_valid held in decode,
 and a file register port that answers reads combinationally on the same clock.
 assumes opcode stays put for all four phases, since file_addr is taken straight from it.
 assumes op_valid and opcode come from logic on clk, so they pass no synchroniser.
 the carry and half carry outputs double as the inputs of the decimal adjust,
 so the core sees one set of status bits for both instructions.
*/
// What this block does
// - low nibble above nine or half carry set adds six to low nibble.
// - high nibble above nine or carry set adds six there and sets carry.
// - opcode 0x0007 is decimal adjust of the working register after bcd add.
// - decrement opcode subtracts one from file register; destination zero writes working register.
// - decrement with destination one writes the result back to the file register.
`timescale 1ns/100ps
`include "bcdadj_defs.svh"

module bcdadj_unit
   import bcdadj_pkg::*;
#(
   parameter int unsigned DATA_W = 8,   // working and file register width
   parameter int unsigned OP_W   = 16   // instruction word width
)
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        op_valid,
   input  wire logic [15:0] opcode,
   input  wire logic [7:0]  file_rdata,
   output logic      [7:0]  file_addr,
   output logic      [7:0]  file_wdata,
   output logic             file_we,
   output logic      [7:0]  w_reg,
   output logic             carry_flag,
   output logic             half_carry_flag,
   output logic             negative_flag,
   output logic             overflow_flag,
   output logic             zero_flag,
   output logic             busy,
   output logic             done,
   output logic             illegal_op
);

   // reset synchroniser
   logic                rst_sync1_reg;
   logic                rst_sync_b;

   // state of the instruction in flight
   bcdadj_phase_t       phase_reg;
   logic [15:0]         op_reg;
   logic [7:0]          operand_reg;
   logic [7:0]          result_reg;
   logic                carry_res_reg;
   logic                half_res_reg;
   logic                ov_res_reg;
   logic                is_adjust;
   logic                is_decrement;
   logic                lo_fix;
   logic                hi_fix;
   logic [3:0]          lo_next;
   logic [4:0]          hi_sum;
   logic [8:0]          dec_diff;
   logic [4:0]          dec_half;
   logic                lo_carry;
   logic                write_w;
   logic                write_file;

   // the nibble arithmetic and opcode fields are laid out for a byte datapath
   // and a 16-bit instruction word; any other size would silently misdecode
   if (DATA_W != 8 || OP_W != 16) begin : g_size_check
      $error("bcdadj_unit supports only an 8-bit datapath and 16-bit opcodes");
   end

   // reset is asserted at once but released only after two clock edges
   // so that no flop leaves reset on an edge close to the pin changing
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync1_reg <= 1'b0;
         rst_sync_b    <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_sync_b    <= rst_sync1_reg;
      end
   end

   // decode works on the latched opcode, valid from the read phase on
   assign is_adjust    = (op_reg == `BCDADJ_OP_DECIMAL_ADJUST);
   assign is_decrement = (op_reg[`BCDADJ_DEC_UPPER_MSB:`BCDADJ_DEC_UPPER_LSB] == `BCDADJ_DEC_UPPER_VAL);

   // decimal adjust arithmetic; hi nibble sees the carry out of the low correction
   assign lo_fix  = (operand_reg[3:0] > `BCDADJ_NIBBLE_MAX) || half_carry_flag;
   assign lo_next = lo_fix ? operand_reg[3:0] + `BCDADJ_NIBBLE_FIX : operand_reg[3:0];
   // the high test looks at the nibble as read, not at the corrected one
   assign hi_fix  = (operand_reg[7:4] > `BCDADJ_NIBBLE_MAX) || carry_flag;
   // a corrected low nibble above nine wraps past fifteen; that carry must
   // reach the high nibble or a value such as 0xce would come out as 0x24
   assign lo_carry = lo_fix && (operand_reg[3:0] > `BCDADJ_NIBBLE_MAX);
   assign hi_sum   = {1'b0, operand_reg[7:4]}
                     + (hi_fix ? {1'b0, `BCDADJ_NIBBLE_FIX} : `BCDADJ_NIB_ZERO)
                     + {4'h0, lo_carry};

   // borrow convention: carry set means no borrow
   assign dec_diff = {1'b0, operand_reg} - {1'b0, `BCDADJ_ONE};
   // low nibble borrow on its own, so half carry needs no tap inside the byte adder
   assign dec_half = {1'b0, operand_reg[3:0]} - `BCDADJ_NIB_ONE;

   // destination select: decrement with d=1 goes back to the file register,
   // decimal adjust and decrement with d=0 land in the working register
   assign write_file = is_decrement && op_reg[`BCDADJ_DEST_BIT];
   assign write_w    = is_adjust || (is_decrement && !op_reg[`BCDADJ_DEST_BIT]);

   // file_addr follows the live opcode, not the latched one, so the read in
   // the read phase needs no extra cycle; the core must hold opcode meanwhile
   assign file_addr = opcode[`BCDADJ_ADDR_MSB:0];
   // handshake outputs are decoded straight from the phase, with no added lag
   assign busy      = (phase_reg != BCDADJ_DECODE);
   assign done      = (phase_reg == BCDADJ_WRITE);

   // op_valid is ignored while busy; there is no queue, so the core must
   // wait for the write phase to end before it offers the next opcode
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         phase_reg <= BCDADJ_DECODE;
      end else begin
         unique case (phase_reg)
            BCDADJ_DECODE:  phase_reg <= op_valid ? BCDADJ_READ : BCDADJ_DECODE;
            BCDADJ_READ:    phase_reg <= BCDADJ_PROCESS;
            BCDADJ_PROCESS: phase_reg <= BCDADJ_WRITE;
            BCDADJ_WRITE:   phase_reg <= BCDADJ_DECODE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         op_reg      <= `BCDADJ_OP_RESET;
         operand_reg <= `BCDADJ_ZERO;
      end else if (phase_reg == BCDADJ_DECODE && op_valid) begin
         op_reg <= opcode;
      end else if (phase_reg == BCDADJ_READ) begin
         // adjust works on the working register, decrement on the file register
         operand_reg <= is_adjust ? w_reg : file_rdata;
      end
   end

   // results are held one phase so the write phase only steers them;
   // half carry and overflow keep their last value across an adjust
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         result_reg    <= `BCDADJ_ZERO;
         carry_res_reg <= 1'b0;
         half_res_reg  <= 1'b0;
         ov_res_reg    <= 1'b0;
      end else if (phase_reg == BCDADJ_PROCESS) begin
         if (is_adjust) begin
            result_reg    <= {hi_sum[3:0], lo_next};
            carry_res_reg <= hi_fix || hi_sum[4] || carry_flag;
         end else begin
            result_reg    <= dec_diff[7:0];
            carry_res_reg <= ~dec_diff[8];
            half_res_reg  <= ~dec_half[4];
            // only the most negative byte changes sign when one is taken away
            ov_res_reg    <= (operand_reg == `BCDADJ_OV_OPERAND);
         end
      end
   end

   // write phase: destination select and flag update
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         w_reg      <= `BCDADJ_W_RESET;
         file_wdata <= `BCDADJ_ZERO;
         file_we    <= 1'b0;
      end else begin
         file_we <= 1'b0;
         // file_we is a one-cycle pulse that stands during the write phase
         if (phase_reg == BCDADJ_PROCESS && write_file) begin
            file_wdata <= dec_diff[7:0];
            file_we    <= 1'b1;
         end
         if (phase_reg == BCDADJ_WRITE) begin
            if (write_w) begin
               w_reg <= result_reg;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         carry_flag      <= 1'b0;
         half_carry_flag <= 1'b0;
         negative_flag   <= 1'b0;
         overflow_flag   <= 1'b0;
         zero_flag       <= 1'b0;
      end else if (phase_reg == BCDADJ_WRITE) begin
         // decimal adjust touches only carry; the other four flags keep their values
         if (is_adjust) begin
            carry_flag <= carry_res_reg;
         end else if (is_decrement) begin
            carry_flag      <= carry_res_reg;
            half_carry_flag <= half_res_reg;
            negative_flag   <= result_reg[7];
            overflow_flag   <= ov_res_reg;
            zero_flag       <= (result_reg == `BCDADJ_ZERO);
         end
      end
   end

   // flags an opcode this unit does not execute; nothing is written for it
   // the pulse comes one cycle after the write phase, when busy is already low
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         illegal_op <= 1'b0;
      end else begin
         illegal_op <= (phase_reg == BCDADJ_WRITE) && !is_adjust && !is_decrement;
      end
   end

endmodule : bcdadj_unit

// file: bcdadj_unit_assertions.sv
/* checker for bcdadj_unit port timing and results.
   assumes the bench holds opcode and file_rdata for the whole instruction. */
`timescale 1ns/100ps
module bcdadj_unit_checker (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        op_valid,
   input wire logic        file_we,
   input wire logic        carry_flag,
   input wire logic        half_carry_flag,
   input wire logic        negative_flag,
   input wire logic        overflow_flag,
   input wire logic        zero_flag,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        illegal_op,
   input wire logic [15:0] opcode,
   input wire logic [7:0]  file_rdata,
   input wire logic [7:0]  file_addr,
   input wire logic [7:0]  file_wdata,
   input wire logic [7:0]  w_reg
);
   logic is_dec;
   logic is_adj;
   assign is_dec = opcode[15:10] == 6'h01;
   assign is_adj = opcode == 16'h0007;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   take_done_a: assert property ((op_valid && !busy && (is_adj || is_dec)) |-> ##3 done)
      else $error("done not three cycles after take");
   busy_span_a: assert property ((op_valid && !busy) |=> busy [*3] ##1 !busy)
      else $error("busy span wrong");
   we_dest_a: assert property (file_we |-> done && is_dec && opcode[9])
      else $error("file write without decrement to file");
   wdata_a: assert property ((done && is_dec && opcode[9]) |-> file_we && file_wdata == $past(file_rdata, 2) - 8'h01)
      else $error("file write data wrong");
   dec_w_a: assert property ((done && is_dec && !opcode[9]) |=> w_reg == $past(file_rdata, 3) - 8'h01)
      else $error("working register after decrement wrong");
   dec_flags_a: assert property ((done && is_dec) |=> zero_flag == ($past(file_rdata, 3) == 8'h01)
      && carry_flag == ($past(file_rdata, 3) != 8'h00))
      else $error("decrement flags wrong");
   adj_carry_a: assert property ((done && is_adj && carry_flag) |=> carry_flag)
      else $error("adjust dropped carry");
   adj_lo_a: assert property ((done && is_adj && (w_reg[3:0] > 4'h9 || half_carry_flag))
      |=> w_reg[3:0] == 4'($past(w_reg) + 8'h06))
      else $error("low nibble not corrected");
endmodule : bcdadj_unit_checker
bind bcdadj_unit bcdadj_unit_checker bcdadj_unit_checker_inst (.*);

// file: bcdadj_unit_tb_top.sv
/* self-checking bench for bcdadj_unit: decrement then adjust per row, then corner cases.
   assumes the checker is bound through its own file. */
`timescale 1ns/100ps
module bcdadj_unit_tb_top;
   import bcdadj_pkg::*;
   logic clk, rst_b, op_valid, file_we, cf, hf, nf, of, zf, busy, done, ill, done_s, we_s;
   logic [15:0] opcode;
   logic [7:0]  file_rdata, file_addr, file_wdata, w_reg, wd_s, r, last_w;
   logic [8:0]  e;
   int          err_total, cmp_count;
   logic [7:0]  rows [5] = '{8'h00, 8'hA6, 8'h01, 8'hCF, 8'h80};
   bcdadj_unit bcdadj_unit_inst (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .opcode(opcode),
      .file_rdata(file_rdata), .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
      .w_reg(w_reg), .carry_flag(cf), .half_carry_flag(hf), .negative_flag(nf), .overflow_flag(of),
      .zero_flag(zf), .busy(busy), .done(done), .illegal_op(ill));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic end_sim;
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // fixed phase count: results are sampled in the write cycle and the cycle after
   task automatic run(input logic [15:0] op, input logic [7:0] rd);
      opcode = op;
      file_rdata = rd;
      op_valid = 1'b1;
      @(posedge clk); #1 op_valid = 1'b0;
      repeat (2) @(posedge clk);
      #1 {done_s, we_s, wd_s} = {done, file_we, file_wdata};
      @(posedge clk); #1;
   endtask : run
   function automatic logic [8:0] daw_ref(input logic [7:0] w, input logic c, input logic dc);
      logic hi;
      logic [8:0] s;
      hi = w[7:4] > 4'h9 || c;
      s = {1'b0, w} + ((w[3:0] > 4'h9 || dc) ? 9'h006 : 9'h000) + (hi ? 9'h060 : 9'h000);
      return {s[8] | hi, s[7:0]};
   endfunction : daw_ref
   initial begin
      #20000 err_total++;
      end_sim();
   end
   initial begin
      {rst_b, op_valid, opcode, file_rdata, err_total, cmp_count} = '0;
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      foreach (rows[i]) begin
         r = rows[i] - 8'h01;
         run(16'h0420, rows[i]);
         chk("dec_w", r, w_reg);
         chk("dec_flags", {3'b0, rows[i] != 0, rows[i][3:0] != 0, r[7], rows[i] == 8'h80, r == 0},
            {3'b0, cf, hf, nf, of, zf});
         e = daw_ref(r, rows[i] != 8'h00, rows[i][3:0] != 4'h0);
         run(16'h0007, 8'h00);
         chk("daw_w", e[7:0], w_reg);
         chk("daw_c", {7'b0, e[8]}, {7'b0, cf});
         chk("daw_done", 8'h01, {7'b0, done_s});
      end
      last_w = w_reg;
      run(16'h0644, 8'h80);
      chk("dec_we", 8'h01, {7'b0, we_s});
      chk("dec_wdata", 8'h7F, wd_s);
      chk("dec_keep_w", last_w, w_reg);
      chk("dec_addr", 8'h44, file_addr);
      chk("dec_ill", 8'h00, {7'b0, ill});
      run(16'h0107, 8'h00);
      chk("odd_op_w", last_w, w_reg);
      chk("odd_op_we", 8'h00, {7'b0, we_s});
      chk("odd_op_ill", 8'h01, {7'b0, ill});
      rst_b = 1'b0;
      #1 chk("rst_w", 8'h00, w_reg);
      chk("rst_flags", 8'h00, {3'b0, cf, hf, nf, of, zf});
      end_sim();
   end
endmodule : bcdadj_unit_tb_top
